// ==== rtl/phy_mgmt_map.svh ====
// register offsets, field positions, reset values and frame counts
`ifndef PHY_MGMT_MAP_SVH
`define PHY_MGMT_MAP_SVH

`define REG_PORTAL_CTRL    5'h0d
`define REG_PORTAL_WIN     5'h0e
`define REG_CTRL_TWO       5'h1f

`define CTRL_TWO_RESET     16'h8100
`define PORTAL_CTRL_RESET  16'h0000
`define PORTAL_WIN_RESET   16'h0000

`define C2_XOVER_ALG       15
`define C2_CROSS_SEL       14
`define C2_XOVER_DIS       13
`define C2_FORCE_LINK      11
`define C2_POWER_SAVE      10
`define C2_INT_LEVEL       9
`define C2_JABBER_EN       8
`define C2_LED_HI          5
`define C2_LED_LO          4
`define C2_TX_DIS          3
`define C2_REM_LOOP        2
`define C2_SQE_TEST        1
`define C2_SCRAM_BYP       0

`define PC_OP_HI           15
`define PC_OP_LO           14
`define PC_DEV_HI          4
`define PC_DEV_LO          0

`define OP_REGISTER        2'h0
`define OP_DATA            2'h1
`define OP_INC_RW          2'h2
`define OP_INC_WR          2'h3

`define LED_MODE_SPEED     2'h0
`define LED_MODE_ACT       2'h1

`define FRAME_OP_READ      2'h2
`define FRAME_OP_WRITE     2'h1
`define PREAMBLE_BITS      6'd32
`define HDR_LAST           4'd11
`define DATA_LAST          4'd15
`define PHY_ADDRESS        5'h01

`define MMD_DEV_0          5'h01
`define MMD_DEV_1          5'h03
`define MMD_DEV_2          5'h07
`define MMD_DEV_3          5'h1f
`define MMD_REG_SPAN       16'h0020

`endif

// ==== rtl/phy_mgmt_pkg.sv ====
// types shared by the management register logic
package phy_mgmt_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_hdr,
    st_ta,
    st_data
  } mgmt_state_e;

endpackage : phy_mgmt_pkg

// ==== rtl/mmd_port_if.sv ====
// carrier between the portal logic and the indirect register store
`timescale 1ns/1ns
interface mmd_port_if;
  logic [4:0]  dev;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        we;
  logic [15:0] rdata;
  logic        hit;

  modport portal (output dev, output addr, output wdata, output we,
                  input rdata, input hit);
  modport store  (input dev, input addr, input wdata, input we,
                  output rdata, output hit);
endinterface : mmd_port_if

// ==== rtl/pin_sync.sv ====
// three-stage synchroniser; level moves once stages two and three agree
`timescale 1ns/1ns
module pin_sync (
  // clock and reset
  input  logic clk_sys,
  input  logic rst_b,
  // pin and clean level
  input  logic pin,
  output logic level
);
  logic [2:0] stage;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule : pin_sync

// ==== rtl/mmd_store.sv ====
// indirect register store: four devices of thirty-two words each
`timescale 1ns/1ns
`include "phy_mgmt_map.svh"
module mmd_store
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input  logic       clk_sys,
  input  logic       rst_b,
  // portal side
  mmd_port_if.store  port
);
  word_t mem [128];

  wire [1:0] dev_idx = (port.dev == `MMD_DEV_0) ? 2'h0 :
                       (port.dev == `MMD_DEV_1) ? 2'h1 :
                       (port.dev == `MMD_DEV_2) ? 2'h2 : 2'h3;
  wire       dev_ok  = (port.dev == `MMD_DEV_0) || (port.dev == `MMD_DEV_1)
                    || (port.dev == `MMD_DEV_2) || (port.dev == `MMD_DEV_3);
  wire [6:0] idx     = {dev_idx, port.addr[4:0]};

  assign port.hit   = dev_ok && (port.addr < `MMD_REG_SPAN);
  // holes in the space read zero and swallow writes
  assign port.rdata = port.hit ? mem[idx] : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (port.we && port.hit) begin
      mem[idx] <= port.wdata;
    end
  end

  property p_hole_reads_zero;
    @(posedge clk_sys) disable iff (!rst_b)
      !port.hit |-> port.rdata == 16'h0000;
  endproperty
  a_hole_reads_zero: assert property (p_hole_reads_zero)
    else $error("unimplemented indirect register did not read zero");

  property p_store_keeps_write;
    @(posedge clk_sys) disable iff (!rst_b)
      port.we && port.hit ##1 $stable(port.dev) && $stable(port.addr)
      |-> port.rdata == $past(port.wdata);
  endproperty
  a_store_keeps_write: assert property (p_store_keeps_write)
    else $error("indirect register lost its written value");
endmodule : mmd_store

// ==== rtl/phy_mgmt_regs.sv ====
// management serial slave with second control register and indirect portal
`timescale 1ns/1ns
`include "phy_mgmt_map.svh"
module phy_mgmt_regs
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input  logic       clk_sys,
  input  logic       rst_b,
  // management serial pins
  input  logic       mdc,
  input  logic       mdio_in,
  output logic       mdio_out,
  output logic       mdio_oe,
  // status from the transceiver core
  input  logic       link_up,
  input  logic       activity,
  input  logic       speed_100,
  input  logic       auto_cross_decision,
  input  logic       int_req,
  // controls to the transceiver core
  output logic       crossover_algorithm_select,
  output logic       auto_crossover_en,
  output logic       pair_crossed,
  output logic       tx_link_ok,
  output logic       power_save_en,
  output logic       jabber_en,
  output logic       tx_enable,
  output logic       remote_loopback,
  output logic       sqe_test_en,
  output logic       scrambler_bypass,
  // pins
  output logic       int_pin,
  output logic       first_indicator_output,
  output logic       second_indicator_output
);

  //////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic        mdc_lvl;
  logic        mdio_lvl;
  logic        mdc_prev;

  pin_sync u_mdc_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin     (mdc),
    .level   (mdc_lvl)
  );

  pin_sync u_mdio_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin     (mdio_in),
    .level   (mdio_lvl)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_lvl;
    end
  end

  wire mdc_rise = mdc_lvl & ~mdc_prev;

  //////////////////////////////////////////////////////////////////////////
  // registers and portal decode

  word_t       ctrl2;
  word_t       ctrl;
  word_t       mmd_addr [32];
  mmd_port_if  u_mif ();

  wire [1:0]  portal_op = ctrl[`PC_OP_HI:`PC_OP_LO];
  wire [4:0]  portal_dev = ctrl[`PC_DEV_HI:`PC_DEV_LO];
  wire word_t cur_addr = mmd_addr[portal_dev];
  // op 00 shows the stored address, any other op the addressed word
  wire word_t win_rd_val = (portal_op == `OP_REGISTER) ? cur_addr
                                                       : u_mif.rdata;

  //////////////////////////////////////////////////////////////////////////
  // management frame engine

  mgmt_state_e state;
  logic [5:0]  pre_cnt;
  logic [3:0]  bit_cnt;
  logic [11:0] hdr;
  word_t       sh;
  logic        rd_act;
  logic        wr_act;
  logic [4:0]  reg_sel;

  wire [11:0] next_hdr = {hdr[10:0], mdio_lvl};
  wire word_t next_sh  = {sh[14:0], mdio_lvl};
  wire        hdr_done = mdc_rise && (state == st_hdr)
                      && (bit_cnt == `HDR_LAST);
  wire        data_done = mdc_rise && (state == st_data)
                       && (bit_cnt == `DATA_LAST);
  wire        hit_phy  = (next_hdr[9:5] == `PHY_ADDRESS);
  wire        wr_fire  = data_done && wr_act;
  wire        rd_fire  = data_done && rd_act;
  wire        win_wr   = wr_fire && (reg_sel == `REG_PORTAL_WIN);
  wire        win_rd   = rd_fire && (reg_sel == `REG_PORTAL_WIN);
  wire        step     = ((portal_op == `OP_INC_RW) && (win_wr || win_rd))
                      || ((portal_op == `OP_INC_WR) && win_wr);

  function automatic word_t read_mux(input logic [4:0] r);
    case (r)
      `REG_CTRL_TWO:    read_mux = ctrl2;
      `REG_PORTAL_CTRL: read_mux = ctrl;
      `REG_PORTAL_WIN:  read_mux = win_rd_val;
      default:          read_mux = 16'h0000;
    endcase
  endfunction : read_mux

  // a read answers with the value seen when the header ends
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state    <= st_idle;
      pre_cnt  <= 6'd0;
      bit_cnt  <= 4'd0;
      hdr      <= 12'h000;
      sh       <= 16'h0000;
      rd_act   <= 1'b0;
      wr_act   <= 1'b0;
      reg_sel  <= 5'h00;
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
    end else if (mdc_rise) begin
      case (state)
        st_idle: begin
          if (mdio_lvl) begin
            if (pre_cnt != `PREAMBLE_BITS) begin
              pre_cnt <= pre_cnt + 6'd1;
            end
          end else begin
            if (pre_cnt == `PREAMBLE_BITS) begin
              state <= st_start;
            end
            pre_cnt <= 6'd0;
          end
        end
        st_start: begin
          bit_cnt <= 4'd0;
          state   <= mdio_lvl ? st_hdr : st_idle;
        end
        st_hdr: begin
          hdr     <= next_hdr;
          bit_cnt <= bit_cnt + 4'd1;
          if (bit_cnt == `HDR_LAST) begin
            state   <= st_ta;
            bit_cnt <= 4'd0;
            reg_sel <= next_hdr[4:0];
            rd_act  <= hit_phy && (next_hdr[11:10] == `FRAME_OP_READ);
            wr_act  <= hit_phy && (next_hdr[11:10] == `FRAME_OP_WRITE);
            sh      <= read_mux(next_hdr[4:0]);
          end
        end
        st_ta: begin
          if (bit_cnt == 4'd0) begin
            bit_cnt  <= 4'd1;
            mdio_oe  <= rd_act;
            mdio_out <= 1'b0;
          end else begin
            bit_cnt  <= 4'd0;
            state    <= st_data;
            mdio_out <= rd_act & sh[15];
            sh       <= {sh[14:0], 1'b0};
          end
        end
        st_data: begin
          sh       <= next_sh;
          mdio_out <= rd_act & sh[15];
          bit_cnt  <= bit_cnt + 4'd1;
          if (bit_cnt == `DATA_LAST) begin
            state    <= st_idle;
            pre_cnt  <= 6'd0;
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
            rd_act   <= 1'b0;
            wr_act   <= 1'b0;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes and portal side effects

  // reserved bits are plain storage, so a read-back shows what was written
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl2 <= `CTRL_TWO_RESET;
      ctrl  <= `PORTAL_CTRL_RESET;
    end else if (wr_fire) begin
      if (reg_sel == `REG_CTRL_TWO) begin
        ctrl2 <= next_sh;
      end
      if (reg_sel == `REG_PORTAL_CTRL) begin
        ctrl <= next_sh;
      end
    end
  end

  // one stored address per device; the step wraps at the top of the space
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        mmd_addr[i] <= `PORTAL_WIN_RESET;
      end
    end else if (win_wr && (portal_op == `OP_REGISTER)) begin
      mmd_addr[portal_dev] <= next_sh;
    end else if (step) begin
      mmd_addr[portal_dev] <= cur_addr + 16'h0001;
    end
  end

  assign u_mif.dev   = portal_dev;
  assign u_mif.addr  = cur_addr;
  assign u_mif.wdata = next_sh;
  assign u_mif.we    = win_wr && (portal_op != `OP_REGISTER);

  mmd_store u_store (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .port    (u_mif)
  );

  //////////////////////////////////////////////////////////////////////////
  // controls to the core

  assign crossover_algorithm_select = ctrl2[`C2_XOVER_ALG];
  assign auto_crossover_en = ~ctrl2[`C2_XOVER_DIS];
  assign power_save_en     = ctrl2[`C2_POWER_SAVE];
  assign jabber_en         = ctrl2[`C2_JABBER_EN];
  assign tx_enable         = ~ctrl2[`C2_TX_DIS];
  assign remote_loopback   = ctrl2[`C2_REM_LOOP];
  assign sqe_test_en       = ctrl2[`C2_SQE_TEST];
  assign scrambler_bypass  = ctrl2[`C2_SCRAM_BYP];

  wire [1:0] led_mode = ctrl2[`C2_LED_HI:`C2_LED_LO];
  // reserved indicator codes keep both indicators dark
  wire next_second = (led_mode == `LED_MODE_SPEED) ? speed_100 :
                     (led_mode == `LED_MODE_ACT)   ? activity : 1'b0;
  wire next_first  = (led_mode == `LED_MODE_SPEED) ? (link_up & ~activity) :
                     (led_mode == `LED_MODE_ACT)   ? link_up : 1'b0;
  wire next_pair   = ctrl2[`C2_XOVER_DIS] ? ctrl2[`C2_CROSS_SEL]
                                          : auto_cross_decision;
  wire next_int    = ctrl2[`C2_INT_LEVEL] ? int_req : ~int_req;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pair_crossed            <= 1'b0;
      tx_link_ok              <= 1'b0;
      int_pin                 <= 1'b1;
      first_indicator_output  <= 1'b0;
      second_indicator_output <= 1'b0;
    end else begin
      pair_crossed            <= next_pair;
      tx_link_ok              <= ctrl2[`C2_FORCE_LINK] | link_up;
      int_pin                 <= next_int;
      first_indicator_output  <= next_first;
      second_indicator_output <= next_second;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  property p_ctrl2_reset;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> ctrl2 == `CTRL_TWO_RESET;
  endproperty
  a_ctrl2_reset: assert property (p_ctrl2_reset)
    else $error("second control register left reset at a wrong value");

  property p_fixed_pairs;
    @(posedge clk_sys) disable iff (!rst_b)
      ctrl2[`C2_XOVER_DIS] ##1 $stable(ctrl2)
      |-> pair_crossed == $past(ctrl2[`C2_CROSS_SEL]);
  endproperty
  a_fixed_pairs: assert property (p_fixed_pairs)
    else $error("fixed pair choice not applied");

  property p_force_link;
    @(posedge clk_sys) disable iff (!rst_b)
      ctrl2[`C2_FORCE_LINK] |=> tx_link_ok;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link did not pass the link gate");

  property p_int_level;
    @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> int_pin == ($past(ctrl2[`C2_INT_LEVEL]) ? $past(int_req)
                                                       : !$past(int_req));
  endproperty
  a_int_level: assert property (p_int_level)
    else $error("interrupt pin polarity wrong");

  property p_led_act;
    @(posedge clk_sys) disable iff (!rst_b)
      led_mode == `LED_MODE_ACT |=>
        second_indicator_output == $past(activity)
        && first_indicator_output == $past(link_up);
  endproperty
  a_led_act: assert property (p_led_act)
    else $error("indicator mapping wrong in activity mode");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_fire && reg_sel == `REG_PORTAL_CTRL |=> ctrl == $past(next_sh);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("portal control write not stored");

  property p_addr_read;
    @(posedge clk_sys) disable iff (!rst_b)
      hdr_done && next_hdr[4:0] == `REG_PORTAL_WIN
      && portal_op == `OP_REGISTER |=> sh == $past(cur_addr);
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("window did not return stored address in op 00");

  property p_post_inc;
    @(posedge clk_sys) disable iff (!rst_b)
      step |=> mmd_addr[$past(portal_dev)] == $past(cur_addr) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("stored address did not advance by one");

  property p_no_read_inc_wr;
    @(posedge clk_sys) disable iff (!rst_b)
      win_rd && portal_op == `OP_INC_WR |=> $stable(mmd_addr[portal_dev]);
  endproperty
  a_no_read_inc_wr: assert property (p_no_read_inc_wr)
    else $error("write-only increment advanced on a read");

  property p_frame_release;
    @(posedge clk_sys) disable iff (!rst_b)
      data_done |=> !mdio_oe;
  endproperty
  a_frame_release: assert property (p_frame_release)
    else $error("data pin still driven after the frame");

endmodule : phy_mgmt_regs

// ==== sim/mgmt_station.sv ====
// station manager model: clocks management frames on mdc and mdio
`timescale 1ns/1ns
`include "phy_mgmt_map.svh"
module mgmt_station (
  // pins toward the device
  output logic mdc,
  output logic mdio_in,
  // device drive of the shared line
  input  logic mdio_out,
  input  logic mdio_oe
);
  logic drv;
  logic drv_oe;

  // the line has a pull-up, so a line released by both ends reads high
  assign mdio_in = drv_oe ? drv : (mdio_oe ? mdio_out : 1'b1);

  initial begin
    mdc    = 1'b0;
    drv    = 1'b1;
    drv_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame of 32 ns bits; data moves while mdc is low, read on the rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] v;
    v  = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdc    = 1'b0;
      drv_oe = (op != `FRAME_OP_READ) || (i >= 18);
      drv    = v[i];
      #16;
      mdc = 1'b1;
      if (i < 16) begin
        rd[i] = mdio_in;
      end
      #16;
    end
    // mdc stands still low between frames
    mdc    = 1'b0;
    drv_oe = 1'b0;
  endtask : frame
endmodule : mgmt_station

// ==== sim/tb_phy_mgmt_regs.sv ====
// self-checking bench for the management register block
`timescale 1ns/1ns
`include "phy_mgmt_map.svh"
`define CHECK(nm, e, g) \
  begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_phy_mgmt_regs
  import phy_mgmt_pkg::*;
;
  logic        clk_sys;
  logic        rst_b;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic        link_up;
  logic        activity;
  logic        speed_100;
  logic        auto_cross_decision;
  logic        int_req;
  logic        crossover_algorithm_select;
  logic        auto_crossover_en;
  logic        pair_crossed;
  logic        tx_link_ok;
  logic        power_save_en;
  logic        jabber_en;
  logic        tx_enable;
  logic        remote_loopback;
  logic        sqe_test_en;
  logic        scrambler_bypass;
  logic        int_pin;
  logic        first_indicator_output;
  logic        second_indicator_output;
  int          err_count;
  int          total_checks;
  word_t       got;
  logic [12:0] e;
  word_t       tbl [7] = '{16'hffff, 16'h0000, 16'h2000, 16'h6800,
                           16'h0210, 16'h0020, 16'h8100};
  logic [4:0]  stv [7] = '{5'b10101, 5'b10110, 5'b00011, 5'b01110,
                           5'b11001, 5'b10100, 5'b10001};
  wire  [12:0] seen = {crossover_algorithm_select, auto_crossover_en,
                       pair_crossed, tx_link_ok, power_save_en, int_pin,
                       jabber_en, first_indicator_output,
                       second_indicator_output, tx_enable, remote_loopback,
                       sqe_test_en, scrambler_bypass};

  phy_mgmt_regs u_dut (
    .clk_sys                    (clk_sys),
    .rst_b                      (rst_b),
    .mdc                        (mdc),
    .mdio_in                    (mdio_in),
    .mdio_out                   (mdio_out),
    .mdio_oe                    (mdio_oe),
    .link_up                    (link_up),
    .activity                   (activity),
    .speed_100                  (speed_100),
    .auto_cross_decision        (auto_cross_decision),
    .int_req                    (int_req),
    .crossover_algorithm_select (crossover_algorithm_select),
    .auto_crossover_en          (auto_crossover_en),
    .pair_crossed               (pair_crossed),
    .tx_link_ok                 (tx_link_ok),
    .power_save_en              (power_save_en),
    .jabber_en                  (jabber_en),
    .tx_enable                  (tx_enable),
    .remote_loopback            (remote_loopback),
    .sqe_test_en                (sqe_test_en),
    .scrambler_bypass           (scrambler_bypass),
    .int_pin                    (int_pin),
    .first_indicator_output     (first_indicator_output),
    .second_indicator_output    (second_indicator_output)
  );

  mgmt_station u_mgr (
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [4:0] ra, input word_t d);
    u_mgr.frame(`FRAME_OP_WRITE, `PHY_ADDRESS, ra, d, got);
  endtask : wr

  task automatic rd(input logic [4:0] ra, input word_t x, input string nm);
    u_mgr.frame(`FRAME_OP_READ, `PHY_ADDRESS, ra, 16'h0000, got);
    `CHECK(nm, x, got)
    // the device lets go of the line a few cycles after the last rise
    repeat (3) @(negedge clk_sys);
    `CHECK("mdio release", 1'b0, mdio_oe)
  endtask : rd

  // expected core controls and pins for a control word and current status
  task automatic outs(input word_t w);
    logic [1:0] m;
    m = w[5:4];
    // outputs settle a few cycles after the last mdc rise is seen
    repeat (6) @(negedge clk_sys);
    e = {w[15], ~w[13], w[13] ? w[14] : auto_cross_decision,
         w[11] | link_up, w[10], w[9] ? int_req : ~int_req, w[8],
         m == 2'h0 ? link_up & ~activity : (m == 2'h1 ? link_up : 1'b0),
         m == 2'h0 ? speed_100 : (m == 2'h1 ? activity : 1'b0),
         ~w[3], w[2], w[1], w[0]};
  endtask : outs

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #160000;
    err_count++;
    stop_test();
  end

  initial begin
    err_count    = 0;
    total_checks = 0;
    rst_b        = 1'b0;
    {link_up, activity, speed_100, auto_cross_decision, int_req} = 5'b10101;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    outs(`CTRL_TWO_RESET);
    `CHECK("reset ctl", e[12:6], seen[12:6])
    `CHECK("reset low", e[3:0], seen[3:0])
    rd(`REG_CTRL_TWO, `CTRL_TWO_RESET, "ctrl two reset");
    rd(`REG_PORTAL_CTRL, `PORTAL_CTRL_RESET, "portal ctrl");
    rd(`REG_PORTAL_WIN, `PORTAL_WIN_RESET, "portal win");
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_sys);
      {link_up, activity, speed_100, auto_cross_decision, int_req} = stv[i];
      wr(`REG_CTRL_TWO, tbl[i]);
      rd(`REG_CTRL_TWO, tbl[i], "ctrl two readback");
      outs(tbl[i]);
      `CHECK("ctl a", e[12:8], seen[12:8])
      `CHECK("ctl b", e[7:4], seen[7:4])
      `CHECK("ctl c", e[3:0], seen[3:0])
    end
    wr(`REG_PORTAL_CTRL, 16'h001f);
    wr(`REG_PORTAL_WIN, 16'h0005);
    wr(`REG_PORTAL_CTRL, 16'h401f);
    wr(`REG_PORTAL_WIN, 16'h1234);
    rd(`REG_PORTAL_WIN, 16'h1234, "op01 data");
    rd(`REG_PORTAL_WIN, 16'h1234, "op01 hold");
    wr(`REG_PORTAL_CTRL, 16'hc01f);
    wr(`REG_PORTAL_WIN, 16'haaaa);
    wr(`REG_PORTAL_WIN, 16'hbbbb);
    rd(`REG_PORTAL_WIN, 16'h0000, "op11 read");
    rd(`REG_PORTAL_WIN, 16'h0000, "op11 hold");
    wr(`REG_PORTAL_CTRL, 16'h001f);
    rd(`REG_PORTAL_WIN, 16'h0007, "op11 addr");
    wr(`REG_PORTAL_WIN, 16'h0005);
    wr(`REG_PORTAL_CTRL, 16'h801f);
    rd(`REG_PORTAL_WIN, 16'haaaa, "run 0");
    rd(`REG_PORTAL_WIN, 16'hbbbb, "run 1");
    rd(`REG_PORTAL_WIN, 16'h0000, "run 2");
    wr(`REG_PORTAL_CTRL, 16'h001f);
    rd(`REG_PORTAL_WIN, 16'h0008, "op10 addr");
    wr(`REG_PORTAL_CTRL, 16'h0003);
    rd(`REG_PORTAL_WIN, 16'h0000, "dev addr");
    wr(`REG_PORTAL_CTRL, 16'h0002);
    wr(`REG_PORTAL_WIN, 16'h0010);
    wr(`REG_PORTAL_CTRL, 16'h8002);
    wr(`REG_PORTAL_WIN, 16'hffff);
    rd(`REG_PORTAL_WIN, 16'h0000, "void data");
    wr(`REG_PORTAL_CTRL, 16'h0002);
    rd(`REG_PORTAL_WIN, 16'h0012, "void addr");
    wr(`REG_PORTAL_CTRL, 16'h7fe7);
    rd(`REG_PORTAL_CTRL, 16'h7fe7, "ctrl rsvd");
    // a second reset in mid-run must restore the documented defaults
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(`REG_CTRL_TWO, `CTRL_TWO_RESET, "ctrl two rerun");
    rd(`REG_PORTAL_CTRL, 16'h0000, "ctrl rerun");
    stop_test();
  end
endmodule : tb_phy_mgmt_regs
